/* logic/mop_core.sv */
// Minus-one instruction datapath with its own register file.
// Assumes one instruction word presented per four-phase cycle.
//
// Overview of operation
// RULE1: Destination bit 0 writes result to accumulator; 1 writes back to register.
// RULE2: Read addressed register and subtract one, wrapping within eight bits.
// RULE3: One word, one cycle: decode, read, process, write in four phases.
// RULE4: Only zero flag changes; set when result is zero, else cleared.
// RULE5: Opcode top six bits 000011, bit 7 destination, bits 6..0 address.
`timescale 1ns/1ps
module mop_core
  import mop_pkg::*;
(
  input  wire logic                CLK,
  input  wire logic                RESET,
  input  wire logic [WORD_W-1:0]   INSTR,
  input  wire logic                LOAD_EN,
  input  wire logic [ADDR_W-1:0]   LOAD_ADDR,
  input  wire logic [DATA_W-1:0]   LOAD_DATA,
  output logic      [DATA_W-1:0]   WACC,
  output logic      [DATA_W-1:0]   STATUS,
  output logic      [1:0]          PHASE,
  output logic                     DONE,
  output logic                     ILLEGAL
);
  import mop_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  mop_mem_if mem_bus ();

  mop_regfile u_regfile
  (
    .CLK  (CLK),
    .port (mem_bus)
  );

  mop_phase_e        phase, next_phase;
  logic [WORD_W-1:0] ir, next_ir;
  logic              hit, next_hit;
  logic [DATA_W-1:0] result, next_result;
  logic [DATA_W-1:0] wacc, next_wacc;
  logic [DATA_W-1:0] status, next_status;
  logic              done, next_done;
  logic              illegal, next_illegal;
  logic              dec_hit;
  logic              dest_reg;
  logic [ADDR_W-1:0] f_addr;

  ////////////////////////////////////////////////////////////////////////////
  assign dec_hit  = (INSTR[OPC_HI:OPC_LO] == OPC_MINUS_ONE);  // [RULE5]
  assign dest_reg = ir[DEST_BIT];                             // [RULE5]
  assign f_addr   = ir[ADDR_HI:ADDR_LO];                      // [RULE5]

  // Register file port shared by outside loading and the datapath
  always_comb
  begin
    mem_bus.addr    = f_addr;
    mem_bus.wr_en   = 1'b0;
    mem_bus.wr_data = result;
    case (phase)
      PH_ONE, PH_THREE:
      begin
        // No operand read under way, so a load may take the port
        if (LOAD_EN)
        begin
          mem_bus.addr    = LOAD_ADDR;
          mem_bus.wr_en   = 1'b1;
          mem_bus.wr_data = LOAD_DATA;
        end
      end
      PH_FOUR:
      begin
        mem_bus.wr_en = hit && dest_reg;                      // [RULE1]
      end
      default:
      begin
        // Read phase keeps the operand address; loads here are dropped
        mem_bus.wr_en = 1'b0;
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // Phase sequencer: free running, one phase per edge
  always_comb
  begin
    next_phase = PH_ONE;
    case (phase)
      PH_ONE:
      begin
        next_phase = PH_TWO;                                  // [RULE3]
      end
      PH_TWO:
      begin
        // Address held this phase; registered read lands next phase
        next_phase = PH_THREE;                                // [RULE3]
      end
      PH_THREE:
      begin
        next_phase = PH_FOUR;                                 // [RULE3]
      end
      PH_FOUR:
      begin
        next_phase = PH_ONE;                                  // [RULE3]
      end
      default:
      begin
        next_phase = PH_ONE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      phase <= PH_ONE;
    end
    else
    begin
      phase <= next_phase;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Decode: word and verdict are caught once, in phase one
  always_comb
  begin
    next_ir      = ir;
    next_hit     = hit;
    next_illegal = illegal;
    if (phase == PH_ONE)
    begin
      next_ir      = INSTR;                                   // [RULE3]
      next_hit     = dec_hit;                                 // [RULE5]
      next_illegal = !dec_hit;                                // [RULE5]
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      ir      <= '0;
      hit     <= 1'b0;
      illegal <= 1'b0;
    end
    else
    begin
      ir      <= next_ir;
      hit     <= next_hit;
      illegal <= next_illegal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Arithmetic: operand is in the read register during phase three
  always_comb
  begin
    next_result = result;
    if (phase == PH_THREE)
    begin
      next_result = mem_bus.rd_data - ONE;                    // [RULE2]
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      result <= DATA_ZERO;
    end
    else
    begin
      result <= next_result;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Accumulator and status move only at the end of a matching word
  always_comb
  begin
    next_wacc   = wacc;
    next_status = status;
    next_done   = 1'b0;
    if (phase == PH_FOUR && hit)
    begin
      if (!dest_reg)
      begin
        next_wacc = result;                                   // [RULE1]
      end
      // Other status bits keep their value
      next_status[ZERO_BIT] = (result == DATA_ZERO);          // [RULE4]
      next_done             = 1'b1;                           // [RULE3]
    end
  end

  always_ff @(posedge CLK or posedge RESET)
  begin
    if (RESET)
    begin
      wacc   <= WACC_RESET;
      status <= STATUS_RESET;
      done   <= 1'b0;
    end
    else
    begin
      wacc   <= next_wacc;
      status <= next_status;
      done   <= next_done;
    end
  end

  assign WACC    = wacc;
  assign STATUS  = status;
  assign PHASE   = phase;
  assign DONE    = done;
  assign ILLEGAL = illegal;
endmodule

/* logic/mop_pkg.sv */
// Constants and types for the minus-one datapath.
// Assumes a single core clock with one phase per clock edge.
package mop_pkg;
  localparam int          WORD_W        = 14;
  localparam int          DATA_W        = 8;
  localparam int          ADDR_W        = 7;
  localparam int          REG_DEPTH     = 128;
  localparam logic [5:0]  OPC_MINUS_ONE = 6'h03;
  localparam int          OPC_HI        = 13;
  localparam int          OPC_LO        = 8;
  localparam int          DEST_BIT      = 7;
  localparam int          ADDR_HI       = 6;
  localparam int          ADDR_LO       = 0;
  localparam int          ZERO_BIT      = 2;
  localparam logic [7:0]  ONE           = 8'h01;
  localparam logic [7:0]  WACC_RESET    = 8'h00;
  localparam logic [7:0]  STATUS_RESET  = 8'h00;
  localparam logic [7:0]  DATA_ZERO     = 8'h00;
  typedef enum logic [1:0] {PH_ONE, PH_TWO, PH_THREE, PH_FOUR} mop_phase_e;
endpackage

/* logic/mop_mem_if.sv */
// Carrier between the datapath and its register file.
// Assumes both ends share the core clock.
`timescale 1ns/1ps
interface mop_mem_if;
  import mop_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic              wr_en;
  logic [DATA_W-1:0] wr_data;
  logic [DATA_W-1:0] rd_data;
  modport core (output addr, output wr_en, output wr_data, input rd_data);
  modport mem  (input addr, input wr_en, input wr_data, output rd_data);
endinterface

/* logic/mop_regfile.sv */
// Data register file, 128 bytes, registered read data.
// Assumes address is stable one clock before data is needed.
`timescale 1ns/1ps
module mop_regfile
  import mop_pkg::*;
(
  input  wire logic CLK,
  mop_mem_if.mem    port
);
  logic [DATA_W-1:0] mem [REG_DEPTH];
  logic [DATA_W-1:0] rd;

  always_ff @(posedge CLK)
  begin
    if (port.wr_en)
    begin
      mem[port.addr] <= port.wr_data;
    end
    rd <= mem[port.addr];
  end
  assign port.rd_data = rd;
endmodule

/* tb/mop_core_asserts.sv */
// Checker for mop_core, bound to its ports.
// Assumes one phase per CLK edge.
`timescale 1ns/1ps
module mop_chk
  import mop_pkg::*;
(
  input logic        CLK,
  input logic        RESET,
  input logic [13:0] INSTR,
  input logic [7:0]  WACC,
  input logic [7:0]  STATUS,
  input logic [1:0]  PHASE,
  input logic        DONE,
  input logic        ILLEGAL
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RESET);
  ////////////////////////////////////////////////////////////////////
  sequence s_walk;
    PHASE == 2'd1 ##1 PHASE == 2'd2 ##1 PHASE == 2'd3 ##1 PHASE == 2'd0;
  endsequence
  property p_walk;
    PHASE == 2'd0 |=> s_walk;
  endproperty
  property p_take;
    PHASE == 2'd0 && INSTR[13:8] == OPC_MINUS_ONE |-> ##4 DONE;
  endproperty
  property p_refuse;
    PHASE == 2'd0 && INSTR[13:8] != OPC_MINUS_ONE |-> ##4 ILLEGAL && !DONE;
  endproperty
  // Destination bit recovered from the word taken four edges back
  property p_zflag;
    DONE && ($past(INSTR, 4) & 14'h0080) == 14'h0000
      |-> STATUS[ZERO_BIT] == (WACC == DATA_ZERO);
  endproperty
  property p_keep;
    DONE && ($past(INSTR, 4) & 14'h0080) != 14'h0000 |-> $stable(WACC);
  endproperty
  a_walk: assert property (p_walk) else $error("phase walk broken");
  a_take: assert property (p_take) else $error("no done");
  a_refuse: assert property (p_refuse) else $error("bad word taken");
  a_zflag: assert property (p_zflag) else $error("zero flag wrong");
  a_keep: assert property (p_keep) else $error("accumulator hit");
endmodule
bind mop_core mop_chk u_chk (.CLK(CLK), .RESET(RESET), .INSTR(INSTR), .WACC(WACC),
  .STATUS(STATUS), .PHASE(PHASE), .DONE(DONE), .ILLEGAL(ILLEGAL));

/* tb/tb.sv */
// Bench for mop_core: table of single ops, then hand cases.
// Assumes nothing else drives the core.
`timescale 1ns/1ps
module tb;
  import mop_pkg::*;
  logic        CLK = 1'b0;
  logic        RESET = 1'b1;
  logic [13:0] INSTR = 14'h0000;
  logic        LOAD_EN = 1'b0;
  logic [6:0]  LOAD_ADDR = 7'h00;
  logic [7:0]  LOAD_DATA = 8'h00;
  logic [7:0]  WACC;
  logic [7:0]  STATUS;
  logic [1:0]  PHASE;
  logic        DONE;
  logic        ILLEGAL;
  int          mismatches = 0;
  int          n_checks = 0;
  // Operand beside expected result
  logic [15:0] rows [4] = '{16'h0100, 16'h00FF, 16'h807F, 16'hFFFE};
  always #2.5 CLK = ~CLK;
  mop_core dut (.CLK(CLK), .RESET(RESET), .INSTR(INSTR), .LOAD_EN(LOAD_EN),
    .LOAD_ADDR(LOAD_ADDR), .LOAD_DATA(LOAD_DATA), .WACC(WACC), .STATUS(STATUS),
    .PHASE(PHASE), .DONE(DONE), .ILLEGAL(ILLEGAL));
  ////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("mismatch at %0t: %h vs %h", $time, seen, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  // Load shares the taking edge; read comes later
  task automatic op(input logic [13:0] w, input logic ld, input logic [7:0] v);
    INSTR = w;
    LOAD_EN = ld;
    LOAD_ADDR = w[6:0];
    LOAD_DATA = v;
    @(posedge CLK);
    #1 LOAD_EN = 1'b0;
    repeat (3) @(posedge CLK);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////
  initial
  begin
    #5000 mismatches++;
    tally_and_finish();
  end
  initial
  begin
    repeat (12) @(posedge CLK);
    chk(STATUS, STATUS_RESET);
    chk({6'h00, PHASE}, 8'h00);
    #1 RESET = 1'b0;
    for (int i = 0; i < 4; i++)
    begin
      op({OPC_MINUS_ONE, 1'b0, 7'(i)}, 1'b1, rows[i][15:8]);
      chk(WACC, rows[i][7:0]);
      chk(STATUS, {5'h00, rows[i][7:0] == 8'h00, 2'h0});
      chk({7'h00, DONE}, 8'h01);
    end
    op({OPC_MINUS_ONE, 8'hFF}, 1'b1, 8'h01);
    chk(WACC, 8'hFE);
    chk(STATUS, 8'h04);
    op({OPC_MINUS_ONE, 8'h7F}, 1'b0, 8'h00);
    chk(WACC, 8'hFF);
    op(14'h0A7F, 1'b0, 8'h00);
    chk({6'h00, ILLEGAL, DONE}, 8'h02);
    chk(WACC, 8'hFF);
    // Mid-run reset clears state but not the register file
    RESET = 1'b1;
    #1;
    chk(WACC, WACC_RESET);
    chk(STATUS, STATUS_RESET);
    chk({6'h00, ILLEGAL, DONE}, 8'h00);
    chk({6'h00, PHASE}, 8'h00);
    @(posedge CLK);
    #1 RESET = 1'b0;
    op({OPC_MINUS_ONE, 1'b0, 7'h7F}, 1'b0, 8'h00);
    chk(WACC, 8'hFF);
    chk(STATUS, 8'h00);
    chk({6'h00, ILLEGAL, DONE}, 8'h01);
    tally_and_finish();
  end
endmodule
